// [rpsc_config_bank.sv]
// The AHB-Lite interface to the registers was decided locally.
`timescale 1ns/10ps

module rpsc_config_bank #(
    parameter int SPACING_W = 16
)
(
    // Clock and reset
    input  wire logic                 mclk,
    input  wire logic                 rst,
    // AHB-Lite slave
    input  wire logic                 hsel,
    input  wire logic [31:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic                      hreadyout,
    output logic                      hresp,
    output logic [31:0]               hrdata,
    // Radio state
    input  wire logic                 txActive,
    input  wire logic                 rxMode,
    input  wire logic [SPACING_W-1:0] slotSpacing,
    // Length byte following the sync word
    input  wire logic                 lenByteValid,
    input  wire logic [7:0]           lenByte,
    // Received address byte
    input  wire logic                 rxAddrValid,
    input  wire logic [7:0]           rxAddr,
    // Packet handler controls
    output rpsc_pkg::rpsc_cfg_t       cfgOut,
    output logic                      whitenOn,
    output logic                      pn9TxOn,
    output logic                      crcAppendOn,
    output logic                      crcCheckOn,
    output logic                      legacyCrcOn,
    // Packet length verdict
    output logic                      lenDone,
    output logic [7:0]                pktLength,
    output logic                      pktLenOk,
    // Address verdict
    output logic                      addrDone,
    output logic                      addrAccept,
    // Synthesizer word
    output logic [23:0]               synthWord
);
    import rpsc_pkg::*;

    // ==========================================================
    // Parameter check
    generate
        if (SPACING_W < 1 || SPACING_W > 16)
        begin : gBadSpacing
            $error("SPACING_W must lie between 1 and 16");
        end
    endgenerate

    // ==========================================================
    // Register access functions

    // Reset image of the whole bank
    function automatic rpsc_cfg_t resetCfg();
        rpsc_cfg_t c;
        logic [7:0] pf;
        logic [7:0] fh;
        pf = `RPSC_RST_PKTFMT;
        fh = `RPSC_RST_FHI;
        c.whitenEnable = pf[`RPSC_PF_WHITEN];
        c.frameFormat  = pf[`RPSC_PF_FMT_HI:`RPSC_PF_FMT_LO];
        c.legacyCrc    = pf[`RPSC_PF_LEGACY];
        c.crcEnable    = pf[`RPSC_PF_CRC];
        c.sizeMode     = pf[`RPSC_PF_SIZE_HI:`RPSC_PF_SIZE_LO];
        c.fixedLength  = `RPSC_RST_LEN;
        c.addrMode     = 2'(`RPSC_RST_ADRCTL);
        c.nodeId       = `RPSC_RST_NODE;
        c.slotIndex    = `RPSC_RST_SLOT;
        c.ifReserved   = 1'b0;
        c.ifWord       = 5'(`RPSC_RST_IFCTL);
        c.tuneOffset   = `RPSC_RST_OFFCTL;
        c.carrierLow   = {fh[5:0], `RPSC_RST_FMID, `RPSC_RST_FLO};
        return c;
    endfunction

    // True when the index names a register of the bank
    function automatic logic isMapped(input logic [15:0] idx);
        return (idx >= `RPSC_IDX_LEN) && (idx <= `RPSC_IDX_FLO);
    endfunction

    // Apply a byte write; fixed and unused bits are dropped
    function automatic rpsc_cfg_t applyWrite(input rpsc_cfg_t c,
                                             input logic [15:0] idx,
                                             input logic [7:0] d);
        rpsc_cfg_t n;
        n = c;
        unique case (idx)
            `RPSC_IDX_LEN:    n.fixedLength = d;
            `RPSC_IDX_ADRCTL: n.addrMode = d[1:0];
            `RPSC_IDX_PKTFMT:
            begin
                n.whitenEnable = d[`RPSC_PF_WHITEN];
                n.frameFormat  = d[`RPSC_PF_FMT_HI:`RPSC_PF_FMT_LO];
                n.legacyCrc    = d[`RPSC_PF_LEGACY];
                n.crcEnable    = d[`RPSC_PF_CRC];
                n.sizeMode     = d[`RPSC_PF_SIZE_HI:`RPSC_PF_SIZE_LO];
            end
            `RPSC_IDX_NODE:   n.nodeId = d;
            `RPSC_IDX_SLOT:   n.slotIndex = d;
            `RPSC_IDX_IFCTL:
            begin
                n.ifReserved = d[`RPSC_IF_RSV];
                n.ifWord     = d[4:0];
            end
            `RPSC_IDX_OFFCTL: n.tuneOffset = d;
            `RPSC_IDX_FHI:    n.carrierLow[21:16] = d[5:0];
            `RPSC_IDX_FMID:   n.carrierLow[15:8] = d;
            `RPSC_IDX_FLO:    n.carrierLow[7:0] = d;
            default:          n = c;
        endcase
        return n;
    endfunction

    // Read image of one register; unused bits read zero
    function automatic logic [7:0] readReg(input rpsc_cfg_t c,
                                           input logic [15:0] idx);
        logic [7:0] r;
        r = 8'h00;
        unique case (idx)
            `RPSC_IDX_LEN:    r = c.fixedLength;
            `RPSC_IDX_ADRCTL: r = {6'h00, c.addrMode};
            `RPSC_IDX_PKTFMT: r = {1'b0, c.whitenEnable, c.frameFormat,
                                   c.legacyCrc, c.crcEnable, c.sizeMode};
            `RPSC_IDX_NODE:   r = c.nodeId;
            `RPSC_IDX_SLOT:   r = c.slotIndex;
            `RPSC_IDX_IFCTL:  r = {2'h0, c.ifReserved, c.ifWord};
            `RPSC_IDX_OFFCTL: r = c.tuneOffset;
            `RPSC_IDX_FHI:    r = {`RPSC_CARRIER_BASE_WORD_TOP, c.carrierLow[21:16]};
            `RPSC_IDX_FMID:   r = c.carrierLow[15:8];
            `RPSC_IDX_FLO:    r = c.carrierLow[7:0];
            default:          r = 8'h00;
        endcase
        return r;
    endfunction

    // ==========================================================
    // Bus and register state
    rpsc_cfg_t    cfg_r;        // Configuration bank
    rpsc_cfg_t    cfg_nxt;
    rpsc_dphase_t dp_r;         // Pending data phase
    rpsc_dphase_t dp_nxt;
    logic [31:0]  hrdata_r;     // Read data
    logic [31:0]  hrdata_nxt;
    logic         hready_r;     // Ready out, never stalls
    logic         hready_nxt;
    logic         addrTaken;    // Address phase accepted
    logic         addrAligned;  // Word aligned, inside index space

    // ==========================================================
    // Bus slave next state
    always_comb
    begin
        addrTaken   = hsel && htrans[1] && hready;
        addrAligned = (haddr[1:0] == 2'h0) && (haddr[31:18] == 14'h0000);
        cfg_nxt     = cfg_r;
        // Write lands in its data phase; unmapped writes dropped
        if (dp_r.valid && dp_r.write && dp_r.mapped)
            cfg_nxt = applyWrite(cfg_r, dp_r.index, hwdata[7:0]);
        // Capture the next address phase
        dp_nxt.valid  = addrTaken;
        dp_nxt.write  = hwrite;
        dp_nxt.index  = haddr[17:2];
        dp_nxt.mapped = addrAligned && isMapped(haddr[17:2]);
        // Read uses the updated bank so a write just before is seen
        hrdata_nxt = 32'h00000000;
        if (addrTaken && !hwrite && dp_nxt.mapped)
            hrdata_nxt = {24'h000000, readReg(cfg_nxt, haddr[17:2])};
        hready_nxt = 1'b1;
    end

    // Bus slave registers
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            cfg_r    <= resetCfg();
            dp_r     <= '0;
            hrdata_r <= 32'h00000000;
            hready_r <= 1'b1;
        end
        else
        begin
            cfg_r    <= cfg_nxt;
            dp_r     <= dp_nxt;
            hrdata_r <= hrdata_nxt;
            hready_r <= hready_nxt;
        end
    end

    // ==========================================================
    // Packet handler controls
    logic       whitenOn_r;     // Whitening in force
    logic       whitenOn_nxt;
    logic       pn9TxOn_r;      // PN9 data source in transmit
    logic       pn9TxOn_nxt;
    logic       crcAppend_r;    // CRC appended in transmit
    logic       crcAppend_nxt;
    logic       crcCheck_r;     // CRC checked in receive
    logic       crcCheck_nxt;
    logic       legacyCrc_r;    // Legacy CRC in force
    logic       legacyCrc_nxt;
    logic       lenDone_r;      // Length verdict strobe
    logic       lenDone_nxt;
    logic [7:0] pktLength_r;    // Length in force
    logic [7:0] pktLength_nxt;
    logic       pktLenOk_r;     // Length acceptable
    logic       pktLenOk_nxt;

    // Control decode and length decision
    always_comb
    begin
        whitenOn_nxt  = cfg_r.whitenEnable;
        // Receive ignores the PN9 setting and runs as normal mode
        pn9TxOn_nxt   = txActive && (cfg_r.frameFormat == `RPSC_FMT_PN9);
        crcAppend_nxt = cfg_r.crcEnable && txActive;
        crcCheck_nxt  = cfg_r.crcEnable && !txActive;
        legacyCrc_nxt = cfg_r.legacyCrc;
        lenDone_nxt   = lenByteValid;
        pktLength_nxt = pktLength_r;
        pktLenOk_nxt  = pktLenOk_r;
        if (lenByteValid)
        begin
            unique case (cfg_r.sizeMode)
                `RPSC_LEN_FIXED:
                begin
                    pktLength_nxt = cfg_r.fixedLength;
                    pktLenOk_nxt  = 1'b1;
                end
                `RPSC_LEN_VAR:
                begin
                    pktLength_nxt = lenByte;
                    pktLenOk_nxt  = (lenByte <= cfg_r.fixedLength);
                end
                default:
                begin
                    // Reserved size modes refuse the packet
                    pktLength_nxt = lenByte;
                    pktLenOk_nxt  = 1'b0;
                end
            endcase
        end
    end

    // Control registers
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            whitenOn_r  <= 1'b0;
            pn9TxOn_r   <= 1'b0;
            crcAppend_r <= 1'b0;
            crcCheck_r  <= 1'b0;
            legacyCrc_r <= 1'b0;
            lenDone_r   <= 1'b0;
            pktLength_r <= 8'h00;
            pktLenOk_r  <= 1'b0;
        end
        else
        begin
            whitenOn_r  <= whitenOn_nxt;
            pn9TxOn_r   <= pn9TxOn_nxt;
            crcAppend_r <= crcAppend_nxt;
            crcCheck_r  <= crcCheck_nxt;
            legacyCrc_r <= legacyCrc_nxt;
            lenDone_r   <= lenDone_nxt;
            pktLength_r <= pktLength_nxt;
            pktLenOk_r  <= pktLenOk_nxt;
        end
    end

    // ==========================================================
    // Address filter and synthesizer word
    rpsc_addr_filter uFilter
    (
        .mclk        (mclk),
        .rst         (rst),
        .addrMode    (cfg_r.addrMode),
        .nodeId      (cfg_r.nodeId),
        .rxAddrValid (rxAddrValid),
        .rxAddr      (rxAddr),
        .addrDone    (addrDone),
        .addrAccept  (addrAccept)
    );

    rpsc_synth_calc #(.SPACING_W(SPACING_W)) uSynth
    (
        .mclk        (mclk),
        .rst         (rst),
        .baseWord    ({`RPSC_CARRIER_BASE_WORD_TOP, cfg_r.carrierLow}),
        .slotIndex   (cfg_r.slotIndex),
        .slotSpacing (slotSpacing),
        .tuneOffset  (cfg_r.tuneOffset),
        .ifWord      (cfg_r.ifWord),
        .rxMode      (rxMode),
        .synthWord   (synthWord)
    );

    // ==========================================================
    // Outputs, each from a flip-flop except hresp, tied low
    assign hreadyout   = hready_r;
    assign hresp       = 1'b0;
    assign hrdata      = hrdata_r;
    assign cfgOut      = cfg_r;
    assign whitenOn    = whitenOn_r;
    assign pn9TxOn     = pn9TxOn_r;
    assign crcAppendOn = crcAppend_r;
    assign crcCheckOn  = crcCheck_r;
    assign legacyCrcOn = legacyCrc_r;
    assign lenDone     = lenDone_r;
    assign pktLength   = pktLength_r;
    assign pktLenOk    = pktLenOk_r;

endmodule

// [rpsc_params.svh]
// Function
// - Bit 6 enables data whitening, resets enabled
// - Format 00 normal, 10 PN9 test transmit
// - Receive path treats PN9 mode as normal
// - Bit 3 selects legacy CRC, resets standard
// - Bit 2 enables CRC append and check
// - Size mode 00 uses fixed length value
// - Size mode 01 takes length from first byte
// - Node identifier filters received packets, resets 00
// - Broadcast accepts address 00 too in mode 10, 00 or FF in mode 11
// - Slot index times spacing added to base
// - IF word subtracted from base in receive
// - Signed offset added, step reference over 16384
// - Carrier word over three bytes, top read-only
// - Fixed length value is limit in variable mode
// - Filter mode none, exact, 00, 00 and FF
`ifndef RPSC_PARAMS_SVH
`define RPSC_PARAMS_SVH

// ==========================================================
// Register indices (byte address is four times the index)
`define RPSC_IDX_LEN     16'hDF02
`define RPSC_IDX_ADRCTL  16'hDF03
`define RPSC_IDX_PKTFMT  16'hDF04
`define RPSC_IDX_NODE    16'hDF05
`define RPSC_IDX_SLOT    16'hDF06
`define RPSC_IDX_IFCTL   16'hDF07
`define RPSC_IDX_OFFCTL  16'hDF08
`define RPSC_IDX_FHI     16'hDF09
`define RPSC_IDX_FMID    16'hDF0A
`define RPSC_IDX_FLO     16'hDF0B

// ==========================================================
// Field positions in the packet format and IF control registers
`define RPSC_PF_WHITEN   6
`define RPSC_PF_FMT_HI   5
`define RPSC_PF_FMT_LO   4
`define RPSC_PF_LEGACY   3
`define RPSC_PF_CRC      2
`define RPSC_PF_SIZE_HI  1
`define RPSC_PF_SIZE_LO  0
`define RPSC_IF_RSV      5

// ==========================================================
// Reset values
`define RPSC_RST_PKTFMT  8'h45
`define RPSC_RST_LEN     8'hFF
`define RPSC_RST_ADRCTL  8'h00
`define RPSC_RST_NODE    8'h00
`define RPSC_RST_SLOT    8'h00
`define RPSC_RST_IFCTL   8'h0F
`define RPSC_RST_OFFCTL  8'h00
`define RPSC_RST_FHI     8'h5E
`define RPSC_RST_FMID    8'hC4
`define RPSC_RST_FLO     8'hEC
`define RPSC_CARRIER_BASE_WORD_TOP    2'h1

// ==========================================================
// Field codes
`define RPSC_FMT_NORMAL  2'h0
`define RPSC_FMT_PN9     2'h2
`define RPSC_LEN_FIXED   2'h0
`define RPSC_LEN_VAR     2'h1
`define RPSC_ADR_NONE    2'h0
`define RPSC_ADR_EXACT   2'h1
`define RPSC_ADR_BC0     2'h2
`define RPSC_ADR_BCBOTH  2'h3
`define RPSC_BCAST_LO    8'h00
`define RPSC_BCAST_HI    8'hFF

`endif

// [rpsc_pkg.sv]
`include "rpsc_params.svh"

package rpsc_pkg;

    // ==========================================================
    // Configuration held by the bank
    typedef struct packed {
        logic        whitenEnable;    // Data whitening on
        logic [1:0]  frameFormat;     // Normal or PN9 test transmit
        logic        legacyCrc;       // Alternate CRC implementation
        logic        crcEnable;       // CRC generate and check
        logic [1:0]  sizeMode;        // Fixed or variable length
        logic [7:0]  fixedLength;     // Length or maximum length
        logic [1:0]  addrMode;        // Address filter mode
        logic [7:0]  nodeId;          // Node filter identifier
        logic [7:0]  slotIndex;       // Channel index
        logic        ifReserved;      // Reserved read/write bit
        logic [4:0]  ifWord;          // Intermediate frequency word
        logic [7:0]  tuneOffset;      // Signed synthesizer offset
        logic [21:0] carrierLow;      // Writable carrier word bits
    } rpsc_cfg_t;

    // ==========================================================
    // AHB data phase bookkeeping
    typedef struct packed {
        logic        valid;           // Data phase in progress
        logic        write;           // Phase is a write
        logic        mapped;          // Address hits a register
        logic [15:0] index;           // Register index
    } rpsc_dphase_t;

endpackage

// [rpsc_addr_filter.sv]
`timescale 1ns/10ps

module rpsc_addr_filter
(
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       rst,
    // Filter settings
    input  wire logic [1:0] addrMode,
    input  wire logic [7:0] nodeId,
    // Received address byte
    input  wire logic       rxAddrValid,
    input  wire logic [7:0] rxAddr,
    // Verdict
    output logic            addrDone,
    output logic            addrAccept
);
    import rpsc_pkg::*;

    logic addrDone_r;     // Verdict strobe
    logic addrDone_nxt;
    logic addrAccept_r;   // Verdict value
    logic addrAccept_nxt;

    // ==========================================================
    // Verdict computation
    always_comb
    begin
        addrDone_nxt   = rxAddrValid;
        addrAccept_nxt = addrAccept_r;
        if (rxAddrValid)
        begin
            unique case (addrMode)
                `RPSC_ADR_NONE:   addrAccept_nxt = 1'b1;
                `RPSC_ADR_EXACT:  addrAccept_nxt = (rxAddr == nodeId);
                `RPSC_ADR_BC0:    addrAccept_nxt = (rxAddr == nodeId) ||
                                                   (rxAddr == `RPSC_BCAST_LO);
                `RPSC_ADR_BCBOTH: addrAccept_nxt = (rxAddr == nodeId) ||
                                                   (rxAddr == `RPSC_BCAST_LO) ||
                                                   (rxAddr == `RPSC_BCAST_HI);
            endcase
        end
    end

    // Verdict registers
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            addrDone_r   <= 1'b0;
            addrAccept_r <= 1'b0;
        end
        else
        begin
            addrDone_r   <= addrDone_nxt;
            addrAccept_r <= addrAccept_nxt;
        end
    end

    assign addrDone   = addrDone_r;
    assign addrAccept = addrAccept_r;

endmodule

// [rpsc_synth_calc.sv]
`timescale 1ns/10ps

module rpsc_synth_calc #(
    parameter int SPACING_W = 16
)
(
    // Clock and reset
    input  wire logic                 mclk,
    input  wire logic                 rst,
    // Frequency settings
    input  wire logic [23:0]          baseWord,
    input  wire logic [7:0]           slotIndex,
    input  wire logic [SPACING_W-1:0] slotSpacing,
    input  wire logic [7:0]           tuneOffset,
    input  wire logic [4:0]           ifWord,
    input  wire logic                 rxMode,
    // Word for the synthesizer
    output logic [23:0]               synthWord
);
    import rpsc_pkg::*;

    logic [25:0] slotStep;     // Slot index times spacing
    logic [25:0] offsetStep;   // Offset in carrier word units
    logic [25:0] ifStep;       // IF in carrier word units
    logic [25:0] sum;          // Wide sum before truncation
    logic [23:0] synthWord_r;  // Registered result
    logic [23:0] synthWord_nxt;

    // ==========================================================
    // Word arithmetic; carrier unit is reference over 65536
    always_comb
    begin
        slotStep   = {18'h00000, slotIndex} *
                     {{(26 - SPACING_W){1'b0}}, slotSpacing};
        // Offset step is four carrier units, sign extended
        offsetStep = {{16{tuneOffset[7]}}, tuneOffset, 2'h0};
        // IF step is sixty-four carrier units, only in receive
        ifStep     = rxMode ? {15'h0000, ifWord, 6'h00} : 26'h0000000;
        sum        = {2'h0, baseWord} + slotStep + offsetStep - ifStep;
        synthWord_nxt = sum[23:0];
    end

    // Result register
    always_ff @(posedge mclk)
    begin
        if (rst)
            synthWord_r <= 24'h000000;
        else
            synthWord_r <= synthWord_nxt;
    end

    assign synthWord = synthWord_r;

endmodule

// [rpsc_config_bank_assertions.sv]
`timescale 1ns/10ps
// ====================
// Port checker for the configuration bank
module rpsc_cfg_chk
(
    // Clock and reset
    input wire logic                mclk,
    input wire logic                rst,
    // Bus
    input wire logic                hsel,
    input wire logic [1:0]          htrans,
    input wire logic                hwrite,
    input wire logic                hready,
    input wire logic [31:0]         hrdata,
    // Radio side inputs
    input wire logic                txActive,
    input wire logic                lenByteValid,
    input wire logic [7:0]          lenByte,
    input wire logic                rxAddrValid,
    input wire logic [7:0]          rxAddr,
    // Controls and verdicts
    input wire rpsc_pkg::rpsc_cfg_t cfgOut,
    input wire logic                whitenOn,
    input wire logic                pn9TxOn,
    input wire logic                crcAppendOn,
    input wire logic                crcCheckOn,
    input wire logic                legacyCrcOn,
    input wire logic                lenDone,
    input wire logic [7:0]          pktLength,
    input wire logic                pktLenOk,
    input wire logic                addrDone,
    input wire logic                addrAccept
);
    import rpsc_pkg::*;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // Address verdict from mode, node and received byte
    function automatic logic accept(logic [1:0] m, logic [7:0] n, logic [7:0] a);
        return (m == 2'h0) || (a == n) || (m[1] && a == 8'h00) || (m == 2'h3 && a == 8'hFF);
    endfunction
    a_whiten_follow: assert property (!$past(rst) |-> whitenOn == $past(cfgOut.whitenEnable))
        else $error("whitening flag wrong");
    a_legacy_follow: assert property (!$past(rst) |-> legacyCrcOn == $past(cfgOut.legacyCrc))
        else $error("legacy crc flag wrong");
    a_pn9_tx_only: assert property (!$past(rst) |-> pn9TxOn ==
        ($past(txActive) && $past(cfgOut.frameFormat) == 2'h2)) else $error("test mode flag wrong");
    a_crc_split: assert property (!$past(rst) |-> crcAppendOn == $past(cfgOut.crcEnable && txActive)
        && crcCheckOn == $past(cfgOut.crcEnable && !txActive)) else $error("crc flags wrong");
    a_len_strobe: assert property (!$past(rst) |-> lenDone == $past(lenByteValid))
        else $error("length strobe wrong");
    a_len_fixed: assert property (lenByteValid && cfgOut.sizeMode == 2'h0 |=>
        pktLength == $past(cfgOut.fixedLength) && pktLenOk) else $error("fixed length wrong");
    a_len_var: assert property (lenByteValid && cfgOut.sizeMode == 2'h1 |=> pktLength == $past(lenByte)
        && pktLenOk == ($past(lenByte) <= $past(cfgOut.fixedLength))) else $error("variable length wrong");
    a_addr_verdict: assert property (rxAddrValid |=> addrDone && addrAccept ==
        accept($past(cfgOut.addrMode), $past(cfgOut.nodeId), $past(rxAddr))) else $error("addr verdict");
    a_idle_rdata: assert property (!$past(hsel && htrans[1] && hready && !hwrite) |-> hrdata == 0)
        else $error("read data outside a read");
    a_read_upper: assert property (hrdata[31:8] == 24'h0)
        else $error("upper read bits set");
    // Main scenarios reached
    c_pn9: cover property (pn9TxOn);
    c_len_var_bad: cover property (lenDone && !pktLenOk);
    c_addr_reject: cover property (addrDone && !addrAccept);
endmodule

bind rpsc_config_bank rpsc_cfg_chk chk (.*);

// [rpsc_config_bank_bench.sv]
`timescale 1ns/10ps
`include "rpsc_params.svh"
// ====================
// Self-checking bench for the configuration bank
module rpsc_config_bank_bench;
    import rpsc_pkg::*;
    // Design signals
    logic mclk, rst, hsel, hwrite, hreadyout, hresp, txActive, rxMode;
    logic lenByteValid, rxAddrValid, whitenOn, pn9TxOn, crcAppendOn, crcCheckOn;
    logic legacyCrcOn, lenDone, pktLenOk, addrDone, addrAccept;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [15:0] slotSpacing;
    logic [7:0] lenByte, rxAddr, pktLength, v;
    logic [23:0] synthWord;
    rpsc_cfg_t cfgOut;
    int mismatches = 0;
    int numChecks = 0;
    // Expected reset image from 0xDF02 upward, last slot unmapped
    logic [7:0] rstImg [11] = '{8'hFF, 8'h00, 8'h45, 8'h00, 8'h00, 8'h0F, 8'h00,
                                8'h5E, 8'hC4, 8'hEC, 8'h00};
    // Write index, data and read-back value
    logic [15:0] wIdx [6] = '{16'hDF04, 16'hDF03, 16'hDF07, 16'hDF09, 16'hDF0C, 16'hDF08};
    logic [7:0] wDat [6] = '{8'hF7, 8'hFF, 8'hFF, 8'h00, 8'hFF, 8'h80};
    logic [7:0] wExp [6] = '{8'h77, 8'h03, 8'h3F, 8'h40, 8'h00, 8'h80};
    logic [7:0] fmts [4] = '{8'h45, 8'h64, 8'h30, 8'h1B};
    logic [7:0] lenIn [5] = '{8'h55, 8'h20, 8'h21, 8'h10, 8'h05};
    logic [1:0] lenMode [5] = '{2'h0, 2'h1, 2'h1, 2'h3, 2'h2};
    logic [7:0] adrs [4] = '{8'h5A, 8'h00, 8'hFF, 8'h33};

    rpsc_config_bank uut (.*, .hready(hreadyout));

    // Clock
    initial
    begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    // Compare one result
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        numChecks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One AHB single transfer, entered just after a rising edge
    task automatic bus(input logic wr, input logic [15:0] idx, input logic [7:0] wd,
                       output logic [31:0] q);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {14'h0, idx, 2'h0};
        do @(posedge mclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        do @(posedge mclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask

    // Length or address byte strobe, then its one-cycle done flag
    task automatic strobe(input logic isAddr, input logic [7:0] b);
        lenByteValid <= !isAddr;
        rxAddrValid <= isAddr;
        lenByte <= b;
        rxAddr <= b;
        @(posedge mclk);
        lenByteValid <= 1'b0;
        rxAddrValid <= 1'b0;
        @(posedge mclk);
        chk("done flag", 32'h1, {31'h0, isAddr ? addrDone : lenDone});
    endtask

    // Verdict and end of run
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", numChecks, mismatches);
        if (mismatches == 0 && numChecks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Watchdog against a hung handshake
    initial
    begin
        #100us;
        mismatches++;
        report_and_stop();
    end

    // Test sequence
    initial
    begin
        rst = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        txActive = 1'b0;
        rxMode = 1'b0;
        slotSpacing = 16'h0100;
        lenByteValid = 1'b0;
        lenByte = 8'h0;
        rxAddrValid = 1'b0;
        rxAddr = 8'h0;
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        for (int i = 0; i < 11; i++)
        begin
            bus(1'b0, 16'hDF02 + 16'(i), 8'h0, rd);
            chk("reset value", {24'h0, rstImg[i]}, rd);
        end
        $display("test reset values done");
        bus(1'b1, `RPSC_IDX_SLOT, 8'h02, rd);
        bus(1'b1, `RPSC_IDX_OFFCTL, 8'hFF, rd);
        for (int r = 0; r < 2; r++)
        begin
            rxMode <= r[0];
            repeat (3) @(posedge mclk);
            chk("synth word", 24'h5EC4EC + 24'h200 - 24'h4 - (r ? 24'h3C0 : 24'h0), synthWord);
        end
        $display("test synthesizer word done");
        for (int i = 0; i < 6; i++)
        begin
            bus(1'b1, wIdx[i], wDat[i], rd);
            bus(1'b0, wIdx[i], 8'h0, rd);
            chk("read back", {24'h0, wExp[i]}, rd);
        end
        $display("test access kinds done");
        for (int i = 0; i < 8; i++)
        begin
            v = fmts[i / 2];
            txActive <= i[0];
            bus(1'b1, `RPSC_IDX_PKTFMT, v, rd);
            repeat (3) @(posedge mclk);
            chk("flags", {v[6], v[3], i[0] && v[5:4] == 2'h2, v[2] && i[0], v[2] && !i[0]},
                {whitenOn, legacyCrcOn, pn9TxOn, crcAppendOn, crcCheckOn});
        end
        txActive <= 1'b0;
        $display("test packet flags done");
        bus(1'b1, `RPSC_IDX_LEN, 8'h20, rd);
        for (int i = 0; i < 5; i++)
        begin
            bus(1'b1, `RPSC_IDX_PKTFMT, {6'h01, lenMode[i]}, rd);
            repeat (2) @(posedge mclk);
            strobe(1'b0, lenIn[i]);
            chk("length ok", lenMode[i] == 0 || (lenMode[i] == 1 && lenIn[i] <= 8'h20), pktLenOk);
            if (lenMode[i] < 2)
                chk("length", lenMode[i] == 0 ? 8'h20 : lenIn[i], pktLength);
        end
        $display("test packet length done");
        bus(1'b1, `RPSC_IDX_NODE, 8'h5A, rd);
        for (int m = 0; m < 4; m++)
        begin
            bus(1'b1, `RPSC_IDX_ADRCTL, 8'(m), rd);
            repeat (2) @(posedge mclk);
            for (int j = 0; j < 4; j++)
            begin
                strobe(1'b1, adrs[j]);
                chk("accept", m == 0 || j == 0 || (m > 1 && j == 1) || (m == 3 && j == 2), addrAccept);
            end
        end
        $display("test address filter done");
        report_and_stop();
    end
endmodule
